// >>> verilog/input_line_filter.sv
// Package of decoder constants and the per-line input filter module
`timescale 1ns/10ps
`default_nettype none

package pulse_decoder_pkg;
  // Clock rate of core_clk
  localparam int CLK_MHZ = 100;
  // Pulse-form field encodings
  localparam logic [3:0] FORM_SIGN_POS = 4'h0;
  localparam logic [3:0] FORM_FWDREV_POS = 4'h1;
  localparam logic [3:0] FORM_QUAD_X1 = 4'h2;
  localparam logic [3:0] FORM_QUAD_X2 = 4'h3;
  localparam logic [3:0] FORM_QUAD_X4 = 4'h4;
  localparam logic [3:0] FORM_SIGN_NEG = 4'h5;
  localparam logic [3:0] FORM_FWDREV_NEG = 4'h6;
  // Filter-select field encodings
  localparam logic [3:0] FILT_LINE_DRIVER = 4'h0;
  localparam logic [3:0] FILT_OPEN_COLLECTOR = 4'h1;
  localparam logic [3:0] FILT_LINE_DRIVER_FAST = 4'h2;
  // Least stable time a level must hold before it is accepted, in ns
  localparam int FILT_LD_NS = 80;
  localparam int FILT_OC_NS = 400;
  localparam int FILT_FAST_NS = 20;
  // Same times as clock counts, rounded up
  localparam int FILT_LD_CYC = (FILT_LD_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_OC_CYC = (FILT_OC_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_FAST_CYC = (FILT_FAST_NS * CLK_MHZ + 999) / 1000;
  // Wait after servo-on before pulses are taken, in ms
  localparam int HOLDOFF_MS = 40;
  localparam int HOLDOFF_CYC = HOLDOFF_MS * CLK_MHZ * 1000;
  // Filter counter width
  localparam int FILT_CNT_W = 8;
  // Step increment codes, two's complement
  localparam logic [1:0] DELTA_NONE = 2'h0;
  localparam logic [1:0] DELTA_FWD = 2'h1;
  localparam logic [1:0] DELTA_REV = 2'h3;
endpackage : pulse_decoder_pkg

module input_line_filter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic raw_line,
  input wire logic [pulse_decoder_pkg::FILT_CNT_W-1:0] stable_cycles,
  output logic level
);
  logic sync_first;
  logic sync_second;
  logic [pulse_decoder_pkg::FILT_CNT_W-1:0] stable_cnt;
  logic [pulse_decoder_pkg::FILT_CNT_W-1:0] next_stable_cnt;
  logic next_level;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first <= raw_line;
      sync_second <= sync_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accept a new level only after it has held for stable_cycles clocks,
  // so edge noise shorter than the window never reaches the decoder
  always_comb begin
    next_level = level;
    next_stable_cnt = '0;
    if (sync_second != level) begin
      if (stable_cnt + 1'b1 >= stable_cycles) begin
        next_level = sync_second;
      end else begin
        next_stable_cnt = stable_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      level <= 1'b0;
      stable_cnt <= '0;
    end else begin
      level <= next_level;
      stable_cnt <= next_stable_cnt;
    end
  end
endmodule // input_line_filter

`default_nettype wire

// >>> verilog/reference_pulse_decoder.sv
// Position-reference pulse-train decoder producing signed step increments
`timescale 1ns/10ps
`default_nettype none

module reference_pulse_decoder #(
  parameter int HOLDOFF_CYCLES = pulse_decoder_pkg::HOLDOFF_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic step_pulse_line,
  input wire logic direction_line,
  input wire logic [3:0] pulse_form_field,
  input wire logic [3:0] filter_select_field,
  input wire logic servo_on,
  output logic step_valid,
  output logic signed [1:0] step_delta,
  output logic pulses_accepted,
  output logic config_error
);
  typedef enum logic [1:0] {
    SERVO_OFF,
    HOLDOFF,
    RUNNING
  } run_state_t;

  logic [3:0] form;
  logic [3:0] filt_sel;
  logic [3:0] next_form;
  logic [3:0] next_filt_sel;
  logic next_pulses_accepted;
  logic [pulse_decoder_pkg::FILT_CNT_W-1:0] filt_cycles;
  logic line_a;
  logic line_b;
  logic a_log;
  logic b_log;
  logic a_prev;
  logic b_prev;
  logic next_a_prev;
  logic next_b_prev;
  logic take_step;
  logic take_fwd;
  logic next_step_valid;
  logic [1:0] next_step_delta;
  logic next_config_error;
  logic bad_form;
  logic bad_filt;
  logic invert;
  run_state_t run_state;
  run_state_t next_run_state;
  logic [31:0] wait_cnt;
  logic [31:0] next_wait_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture
  // Capture at restart
  // Fields are sampled while rst is held, so a change made during operation
  // has no effect until the next restart; no mid-stream form switch glitches
  always_comb begin
    next_form = form;
    next_filt_sel = filt_sel;
    if (rst) begin
      next_form = pulse_form_field;
      next_filt_sel = filter_select_field;
    end
  end

  always_ff @(posedge core_clk) begin
    form <= next_form;
    filt_sel <= next_filt_sel;
  end

  // Unknown codes fall back to the default form and filter
  always_comb begin
    bad_form = (form > pulse_decoder_pkg::FORM_FWDREV_NEG);
    bad_filt = (filt_sel > pulse_decoder_pkg::FILT_LINE_DRIVER_FAST);
    next_config_error = bad_form | bad_filt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input filters
  // Line-driver or open-collector window
  // Fast window passes 4 Mpps pulses
  // The window is shorter than the narrowest legal pulse half at each rate
  always_comb begin
    case (filt_sel)
      pulse_decoder_pkg::FILT_OPEN_COLLECTOR:
        filt_cycles = pulse_decoder_pkg::FILT_CNT_W'(pulse_decoder_pkg::FILT_OC_CYC);
      pulse_decoder_pkg::FILT_LINE_DRIVER_FAST:
        filt_cycles = pulse_decoder_pkg::FILT_CNT_W'(pulse_decoder_pkg::FILT_FAST_CYC);
      default:
        filt_cycles = pulse_decoder_pkg::FILT_CNT_W'(pulse_decoder_pkg::FILT_LD_CYC);
    endcase
  end

  input_line_filter filt_a (
    .core_clk(core_clk),
    .rst(rst),
    .raw_line(step_pulse_line),
    .stable_cycles(filt_cycles),
    .level(line_a)
  );

  input_line_filter filt_b (
    .core_clk(core_clk),
    .rst(rst),
    .raw_line(direction_line),
    .stable_cycles(filt_cycles),
    .level(line_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Logic polarity
  // Negative logic inverts both lines
  always_comb begin
    invert = (form == pulse_decoder_pkg::FORM_SIGN_NEG) ||
             (form == pulse_decoder_pkg::FORM_FWDREV_NEG);
    a_log = line_a ^ invert;
    b_log = line_b ^ invert;
    next_a_prev = a_log;
    next_b_prev = b_log;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Servo-on hold-off
  // Drop early pulses
  // Pulses inside the hold-off are discarded; this also swallows any
  // spurious edge as the filters settle after reset
  always_comb begin
    next_run_state = run_state;
    next_wait_cnt = wait_cnt;
    case (run_state)
      SERVO_OFF: begin
        next_wait_cnt = '0;
        if (servo_on) begin
          next_run_state = HOLDOFF;
        end
      end
      HOLDOFF: begin
        if (!servo_on) begin
          next_run_state = SERVO_OFF;
        end else if (wait_cnt + 32'h1 >= 32'(HOLDOFF_CYCLES)) begin
          next_run_state = RUNNING;
        end else begin
          next_wait_cnt = wait_cnt + 32'h1;
        end
      end
      RUNNING: begin
        if (!servo_on) begin
          next_run_state = SERVO_OFF;
        end
      end
      default: begin
        next_run_state = SERVO_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_state <= SERVO_OFF;
      wait_cnt <= 32'h0;
    end else begin
      run_state <= next_run_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step decode, from the previous and present logical line levels
  // Form selection
  always_comb begin
    take_step = 1'b0;
    take_fwd = 1'b0;
    case (form)
      pulse_decoder_pkg::FORM_SIGN_POS,
      pulse_decoder_pkg::FORM_SIGN_NEG: begin
        take_step = a_log & ~a_prev;
        take_fwd = b_log;
      end
      pulse_decoder_pkg::FORM_FWDREV_POS,
      pulse_decoder_pkg::FORM_FWDREV_NEG: begin
        // Simultaneous edges on both trains cancel and give no step
        take_step = (b_log & ~b_prev) ^ (a_log & ~a_prev);
        take_fwd = b_log & ~b_prev;
      end
      pulse_decoder_pkg::FORM_QUAD_X1: begin
        take_step = a_log & ~a_prev;
        take_fwd = b_log;
      end
      // Quadrature x2 on both A edges
      pulse_decoder_pkg::FORM_QUAD_X2: begin
        take_step = a_log ^ a_prev;
        take_fwd = ~(a_log ^ b_log);
      end
      pulse_decoder_pkg::FORM_QUAD_X4: begin
        // A jump of both phases at once is illegal and is ignored
        take_step = (a_log ^ a_prev) ^ (b_log ^ b_prev);
        take_fwd = b_log ^ a_prev;
      end
      default: begin
        take_step = a_log & ~a_prev;
        take_fwd = b_log;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Increment output
  // Signed plus or minus one
  always_comb begin
    next_step_valid = 1'b0;
    next_step_delta = pulse_decoder_pkg::DELTA_NONE;
    next_pulses_accepted = (next_run_state == RUNNING);
    if (take_step && run_state == RUNNING) begin
      next_step_valid = 1'b1;
      next_step_delta = take_fwd ? pulse_decoder_pkg::DELTA_FWD :
                                   pulse_decoder_pkg::DELTA_REV;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      step_valid <= 1'b0;
      step_delta <= pulse_decoder_pkg::DELTA_NONE;
      pulses_accepted <= 1'b0;
      config_error <= 1'b0;
    end else begin
      a_prev <= next_a_prev;
      b_prev <= next_b_prev;
      step_valid <= next_step_valid;
      step_delta <= next_step_delta;
      pulses_accepted <= next_pulses_accepted;
      config_error <= next_config_error;
    end
  end
endmodule // reference_pulse_decoder

`default_nettype wire

// >>> verification/pulse_decoder_props.sv
// Port checker for the reference pulse decoder
`timescale 1ns/10ps
`default_nettype none
module pulse_decoder_props #(
  parameter int HOLDOFF_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic servo_on,
  input wire logic step_valid,
  input wire logic signed [1:0] step_delta,
  input wire logic pulses_accepted,
  input wire logic config_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Servo-on run length, saturating so a long run cannot wrap
  int on_cnt;
  int next_on_cnt;
  always_comb begin
    next_on_cnt = on_cnt;
    if (!servo_on) begin
      next_on_cnt = 0;
    end else if (on_cnt < HOLDOFF_CYCLES + 8) begin
      next_on_cnt = on_cnt + 1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= next_on_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_delta_idle: assert property (!step_valid |-> step_delta == 2'h0)
    else $error("delta set without a step");
  a_delta_unit: assert property (step_valid |-> step_delta inside {2'h1, 2'h3})
    else $error("step delta not plus or minus one");
  a_off_no_step: assert property (!servo_on [*3] |-> !step_valid)
    else $error("step while servo off");
  a_off_drops: assert property (!servo_on ##1 !servo_on |-> !pulses_accepted)
    else $error("accepting while servo off");
  a_holdoff_min: assert property ($rose(pulses_accepted) |-> on_cnt >= HOLDOFF_CYCLES)
    else $error("hold-off ended early");
  a_holdoff_max: assert property (on_cnt == HOLDOFF_CYCLES + 4 |-> pulses_accepted)
    else $error("hold-off ended late");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !step_valid && !pulses_accepted)
    else $error("activity right after reset");
  a_cfg_steady: assert property (!rst ##1 !rst ##1 !rst |-> $stable(config_error))
    else $error("config error moved while running");
endmodule // pulse_decoder_props
`default_nettype wire

// >>> verification/host_pulse_source.sv
// Host controller model driving the two reference lines
`timescale 1ns/10ps
`default_nettype none
module host_pulse_source (
  input wire logic core_clk,
  output logic line_a,
  output logic line_b
);
  // Cycles each level stands; kept above the filter window by the caller except in the 200 ns open-collector run
  int hold = 11;
  logic inv = 1'b0;
  initial begin
    line_a = 1'b0;
    line_b = 1'b0;
  end
  // each level held for hold cycles
  task automatic put(input logic a, input logic b);
    line_a <= a ^ inv;
    line_b <= b ^ inv;
    repeat (hold) @(posedge core_clk);
  endtask
  task automatic rest(input logic [3:0] form);
    inv = (form == 4'h5) || (form == 4'h6);
    put(1'b0, 1'b0);
  endtask
  // one pulse, or one quadrature cycle, of motion
  task automatic unit(input logic [3:0] form, input logic fwd);
    if (form == 4'h1 || form == 4'h6) begin
      put(!fwd, fwd);
      put(1'b0, 1'b0);
    end else if (form >= 4'h2 && form <= 4'h4) begin
      put(!fwd, fwd);
      put(1'b1, 1'b1);
      put(fwd, !fwd);
      put(1'b0, 1'b0);
    end else begin
      put(1'b0, fwd);
      put(1'b1, fwd);
      put(1'b0, fwd);
    end
  endtask
endmodule // host_pulse_source
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the reference pulse decoder
`timescale 1ns/10ps
`default_nettype none
`define check(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  bad_count++; $display("mismatch %s expected %0d seen %0d", what, exp, got); end end
module testbench;
  localparam int HOLD_OFF = 60;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic servo_on = 1'b0;
  logic [3:0] pulse_form_field = 4'h0;
  logic [3:0] filter_select_field = 4'h0;
  logic line_a;
  logic line_b;
  logic step_valid;
  logic signed [1:0] step_delta;
  logic pulses_accepted;
  logic config_error;
  int bad_count = 0;
  int samples_checked = 0;
  int got_cnt = 0;
  int got_sum = 0;
  always #5 core_clk = ~core_clk;
  host_pulse_source host_pulse_source_i (.core_clk, .line_a, .line_b);
  reference_pulse_decoder #(.HOLDOFF_CYCLES(HOLD_OFF)) reference_pulse_decoder_i (
    .core_clk, .rst, .step_pulse_line(line_a), .direction_line(line_b), .pulse_form_field,
    .filter_select_field, .servo_on, .step_valid, .step_delta, .pulses_accepted, .config_error);
  ////////////////////////////////////////////////////////////////
  // Tally of decoded steps
  always @(posedge core_clk) begin
    if (step_valid === 1'b1) begin
      got_cnt++;
      got_sum += step_delta;
    end
  end
  function automatic int per_unit(input logic [3:0] form);
    return form == 4'h4 ? 4 : (form == 4'h3 ? 2 : 1);
  endfunction
  // legal host level times
  // Above the filter window plus margin, and no faster than 125 ns levels for pulse forms
  // or a 1 us quadrature cycle, so the host never breaks its own rate limits
  function automatic int window(input logic [3:0] filt, input logic [3:0] form);
    if (filt == 4'h1) return 43;
    return (form >= 4'h2 && form <= 4'h4) ? 25 : 13;
  endfunction
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // fields taken under reset, then scrambled while running
  task automatic restart(input logic [3:0] form, input logic [3:0] filt);
    int n;
    rst <= 1'b1;
    servo_on <= 1'b0;
    pulse_form_field <= form;
    filter_select_field <= filt;
    host_pulse_source_i.hold = window(filt, form);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    servo_on <= 1'b1;
    pulse_form_field <= ~form;
    filter_select_field <= ~filt;
    // Lines settle to idle inside the hold-off, so any edge they make is dropped
    host_pulse_source_i.rest(form);
    n = 0;
    while (pulses_accepted !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > HOLD_OFF + 20) begin
        bad_count++;
        wrap_up();
      end
    end
    repeat (60) @(posedge core_clk);
    got_cnt = 0;
    got_sum = 0;
  endtask
  task automatic run(input logic [3:0] form, input logic [3:0] filt, input int units,
                     input logic fwd, input int exp_cnt, input int hold);
    restart(form, filt);
    if (hold != 0) host_pulse_source_i.hold = hold;
    repeat (units) host_pulse_source_i.unit(form, fwd);
    repeat (60) @(posedge core_clk);
    `check("config error", 1'b0, config_error)
    `check("step count", exp_cnt, got_cnt)
    `check("step sum", fwd ? exp_cnt : -exp_cnt, got_sum)
    $display("test form %0d filter %0d done", form, filt);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int f;
    int d;
    int units;
    void'($urandom(32'h559d211b));
    // every form both ways, random filter and length
    for (f = 0; f < 7; f++) begin
      for (d = 0; d < 2; d++) begin
        units = $urandom_range(4, 1);
        run(4'(f), 4'($urandom_range(2, 0)), units, d[0], units * per_unit(4'(f)), 0);
      end
    end
    // a 200 ns level passes the line-driver filter but not open-collector
    run(4'h0, 4'h0, 2, 1'b1, 2, 20);
    run(4'h0, 4'h1, 2, 1'b1, 0, 20);
    // fast filter at the highest rate
    run(4'h4, 4'h2, 3, 1'b0, 12, 0);
    // pulses inside a restarted hold-off are dropped
    restart(4'h0, 4'h0);
    servo_on <= 1'b0;
    @(posedge core_clk);
    servo_on <= 1'b1;
    host_pulse_source_i.unit(4'h0, 1'b1);
    `check("accept flag", 1'b0, pulses_accepted)
    `check("early steps", 0, got_cnt)
    $display("test hold-off done");
    // undefined form and filter codes are flagged
    restart(4'h9, 4'h0);
    `check("config error", 1'b1, config_error)
    restart(4'h0, 4'h3);
    `check("config error", 1'b1, config_error)
    $display("test bad codes done");
    wrap_up();
  end
endmodule // testbench
bind reference_pulse_decoder pulse_decoder_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) props_i (
  .core_clk, .rst, .servo_on, .step_valid, .step_delta, .pulses_accepted, .config_error);
`default_nettype wire
